// File: pwmwg_top.sv
// pulse-width waveform generator with register port
// assumes synchronous inputs, one clock, trigger already in clock domain
`timescale 1ns/1ps
`default_nettype none
module pwmwg_top
   import pwmwg_pkg::*;
#(
   parameter int CNT_W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // system inputs
   input wire logic trigger_in,
   input wire logic emu_suspend,
   input wire logic power_down,
   // outputs
   output logic waveform_out,
   output logic irq,
   output logic dma_sync_request
);
   // counters and registers are written for one fixed width
   if (CNT_W != 32) begin : g_bad_width
      $error("counter width must be 32");
   end

   logic free_r;
   logic irq_enable_r, idle_level_r, lead_level_r;
   logic [1:0] trig_sel_r, mode_r;
   logic [7:0] repeat_count_r;
   logic [31:0] cycle_length_r, lead_span_r;
   logic [31:0] sh_cycle_r, sh_lead_r, cnt_r;
   logic [7:0] per_left_r;
   logic out_r, evt_r, trig_d_r, pd_d_r;
   pwmwg_state_t state_r;
   logic [31:0] rdata_nxt;

   wire wr_cfg = reg_wr && reg_addr == OFS_CFG;
   wire go = reg_wr && reg_addr == OFS_GO && reg_wdata[GO_BIT];
   // reserved codes behave like disabled
   wire mode_on = mode_r == MODE_ONESHOT || mode_r == MODE_CONT;
   wire trig_on = trig_sel_r == TRIG_RISE || trig_sel_r == TRIG_FALL;
   wire halt = emu_suspend && !free_r;
   wire pd_exit = pd_d_r && !power_down;
   wire edge_seen = (trig_sel_r == TRIG_RISE && trigger_in && !trig_d_r)
      || (trig_sel_r == TRIG_FALL && !trigger_in && trig_d_r);
   wire last_cyc = cnt_r >= sh_cycle_r;
   wire oneshot = mode_r == MODE_ONESHOT;
   // period boundary, frozen by suspend
   wire wrap = state_r == ST_RUN && mode_on && !halt && last_cyc;
   wire finish = wrap && oneshot && per_left_r == 8'h00;
   wire start_run = (state_r == ST_ARMED && !halt && (edge_seen || evt_r))
      || (state_r == ST_IDLE && go && !trig_on && mode_on);

   // register file writes; all defaults on reset
   always_ff @(posedge clk) begin
      if (reset) begin
         free_r <= 1'b0;
         irq_enable_r <= 1'b0;
         idle_level_r <= 1'b0;
         lead_level_r <= 1'b0;
         trig_sel_r <= 2'b00;
         mode_r <= 2'b00;
         repeat_count_r <= RST_RPT;
         cycle_length_r <= RST_WORD;
         lead_span_r <= RST_WORD;
      end else if (reg_wr) begin
         if (reg_addr == OFS_UNIT) begin
            free_r <= reg_wdata[UNIT_FREE_BIT];
         end else if (wr_cfg) begin
            irq_enable_r <= reg_wdata[CFG_IRQ_BIT];
            idle_level_r <= reg_wdata[CFG_IDLE_BIT];
            lead_level_r <= reg_wdata[CFG_LEAD_BIT];
            trig_sel_r <= reg_wdata[CFG_TRIG_LSB +: 2];
            mode_r <= reg_wdata[CFG_MODE_LSB +: 2];
         end else if (reg_addr == OFS_RPT) begin
            repeat_count_r <= reg_wdata[7:0];
         end else if (reg_addr == OFS_CYCLE) begin
            cycle_length_r <= reg_wdata;
         end else if (reg_addr == OFS_LEAD) begin
            lead_span_r <= reg_wdata;
         end
      end
   end

   // delayed copies for edge detection
   always_ff @(posedge clk) begin
      if (reset) begin
         trig_d_r <= 1'b0;
         pd_d_r <= 1'b0;
      end else begin
         trig_d_r <= trigger_in;
         pd_d_r <= power_down;
      end
   end

   // generator state; power-down exit stops but keeps registers
   always_ff @(posedge clk) begin
      if (reset || pd_exit || !mode_on) begin
         state_r <= ST_IDLE;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (go && trig_on) begin
                  state_r <= ST_ARMED;
               end else if (start_run) begin
                  state_r <= ST_RUN;
               end
            end
            ST_ARMED: begin
               if (start_run) begin
                  state_r <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (finish) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // edge latched while suspended, used at release
   always_ff @(posedge clk) begin
      if (reset || state_r != ST_ARMED) begin
         evt_r <= 1'b0;
      end else if (halt && edge_seen) begin
         evt_r <= 1'b1;
      end
   end

   // shadow load and period counting; later edges ignored in run
   always_ff @(posedge clk) begin
      if (reset) begin
         sh_cycle_r <= RST_WORD;
         sh_lead_r <= RST_WORD;
         cnt_r <= RST_WORD;
         per_left_r <= RST_RPT;
      end else if (start_run || (wrap && !finish)) begin
         sh_cycle_r <= cycle_length_r;
         sh_lead_r <= lead_span_r;
         cnt_r <= RST_WORD;
         // after a continuous to one-shot switch the count loaded in continuous mode is decremented
         if (start_run || !oneshot || mode_r != MODE_ONESHOT)
            per_left_r <= repeat_count_r;
         else
            per_left_r <= per_left_r - 8'h01;
      end else if (state_r == ST_RUN && !halt) begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   // continuous mode reloads the repeat count at every period boundary
   // output level; zero span shows opposite, large span lead level
   always_ff @(posedge clk) begin
      if (reset) begin
         out_r <= 1'b0;
      end else if (!mode_on) begin
         out_r <= idle_level_r; // disable wins over freeze
      end else if (halt && state_r == ST_RUN) begin
         out_r <= out_r;
      end else if (start_run || (wrap && !finish)) begin
         out_r <= (lead_span_r != 32'h0) ? lead_level_r
            : !lead_level_r;
      end else if (state_r == ST_RUN && !finish) begin
         out_r <= ((cnt_r + 32'h1) < sh_lead_r) ? lead_level_r
            : !lead_level_r;
      end else begin
         out_r <= idle_level_r;
      end
   end

   // interrupt and dma pulse, one cycle, same moment
   always_ff @(posedge clk) begin
      if (reset) begin
         irq <= 1'b0;
         dma_sync_request <= 1'b0;
      end else begin
         // suspend withholds even a start taken while halted
         irq <= irq_enable_r && !halt && ((mode_r == MODE_CONT
            && (start_run || wrap)) || finish);
         dma_sync_request <= irq_enable_r && !halt && ((mode_r == MODE_CONT
            && (start_run || wrap)) || finish);
      end
   end

   assign waveform_out = out_r;

   // read mux
   always_comb begin
      rdata_nxt = 32'h0;
      if (reg_addr == OFS_IDENT) begin
         rdata_nxt = {ID_SCHEME, 2'b00, ID_FUNC, ID_IMPL, ID_MAJOR,
            ID_CUSTOM, ID_MINOR};
      end else if (reg_addr == OFS_UNIT) begin
         rdata_nxt[UNIT_FREE_BIT] = free_r;
      end else if (reg_addr == OFS_CFG) begin
         rdata_nxt[CFG_RUN_BIT] = state_r == ST_RUN;
         rdata_nxt[CFG_PIN_BIT] = out_r;
         rdata_nxt[CFG_IRQ_BIT] = irq_enable_r;
         rdata_nxt[CFG_IDLE_BIT] = idle_level_r;
         rdata_nxt[CFG_LEAD_BIT] = lead_level_r;
         rdata_nxt[CFG_TRIG_LSB +: 2] = trig_sel_r;
         rdata_nxt[CFG_MODE_LSB +: 2] = mode_r;
      end else if (reg_addr == OFS_RPT) begin
         rdata_nxt[7:0] = repeat_count_r;
      end else if (reg_addr == OFS_CYCLE) begin
         rdata_nxt = cycle_length_r;
      end else if (reg_addr == OFS_LEAD) begin
         rdata_nxt = lead_span_r;
      end
   end

   // read data one cycle after strobe, else zero
   always_ff @(posedge clk) begin
      if (reset) reg_rdata <= 32'h0;
      else reg_rdata <= reg_rd ? rdata_nxt : 32'h0;
   end

   // assertions
   property p_dma_eq_irq;
      @(posedge clk) disable iff (reset) dma_sync_request == irq;
   endproperty
   a_dma_eq_irq: assert property (p_dma_eq_irq)
      else $error("dma request differs from interrupt");

   property p_idle_level;
      @(posedge clk) disable iff (reset)
      (!mode_on && !$past(mode_on)) |-> waveform_out == $past(idle_level_r);
   endproperty
   a_idle_level: assert property (p_idle_level)
      else $error("disabled output not at idle level");

   property p_freeze;
      @(posedge clk) disable iff (reset)
      (halt && state_r == ST_RUN && mode_on) |=> $stable(waveform_out);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("output moved during suspend");

   property p_no_irq_halt;
      @(posedge clk) disable iff (reset) halt |=> !irq;
   endproperty
   a_no_irq_halt: assert property (p_no_irq_halt)
      else $error("interrupt during suspend");

   property p_irq_en;
      @(posedge clk) disable iff (reset) !irq_enable_r |=> !irq;
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("interrupt while disabled");

   property p_pd_stop;
      @(posedge clk) disable iff (reset) pd_exit |=> state_r == ST_IDLE;
   endproperty
   a_pd_stop: assert property (p_pd_stop)
      else $error("generator runs after power-down exit");

   sequence s_go_armed;
      state_r == ST_IDLE && go && trig_on && mode_on && !pd_exit;
   endsequence
   property p_arm;
      @(posedge clk) disable iff (reset) s_go_armed |=> state_r == ST_ARMED;
   endproperty
   a_arm: assert property (p_arm)
      else $error("start did not arm edge detection");

   property p_read_zero;
      @(posedge clk) disable iff (reset) !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("read data outside read slot");

   property p_run_bit;
      @(posedge clk) disable iff (reset)
      (reg_rd && reg_addr == OFS_CFG) |=>
         reg_rdata[CFG_RUN_BIT] == ($past(state_r) == ST_RUN);
   endproperty
   a_run_bit: assert property (p_run_bit)
      else $error("run status bit wrong");

   property p_pin_bit;
      @(posedge clk) disable iff (reset)
      (reg_rd && reg_addr == OFS_CFG) |=>
         reg_rdata[CFG_PIN_BIT] == $past(waveform_out);
   endproperty
   a_pin_bit: assert property (p_pin_bit)
      else $error("pin level bit wrong");

   property p_ident;
      @(posedge clk) disable iff (reset)
      (reg_rd && reg_addr == OFS_IDENT) |=> reg_rdata == {ID_SCHEME,
         2'b00, ID_FUNC, ID_IMPL, ID_MAJOR, ID_CUSTOM, ID_MINOR};
   endproperty
   a_ident: assert property (p_ident)
      else $error("identity word wrong");

   property p_evt_latch;
      @(posedge clk) disable iff (reset)
      (state_r == ST_ARMED && halt && edge_seen) |=> evt_r;
   endproperty
   a_evt_latch: assert property (p_evt_latch)
      else $error("edge during suspend not latched");

   // latched edge waiting, then the suspend lifted
   sequence s_edge_held;
      state_r == ST_ARMED && evt_r && mode_on && !pd_exit;
   endsequence
   sequence s_thawed;
      !halt;
   endsequence
   property p_release;
      @(posedge clk) disable iff (reset)
      (s_edge_held ##0 s_thawed) |=> state_r == ST_RUN;
   endproperty
   a_release: assert property (p_release)
      else $error("latched edge did not start counting");

   property p_oneshot_irq;
      @(posedge clk) disable iff (reset)
      (finish && irq_enable_r) |=> irq;
   endproperty
   a_oneshot_irq: assert property (p_oneshot_irq)
      else $error("no interrupt at end of one-shot run");

   property p_cont_irq;
      @(posedge clk) disable iff (reset)
      ((start_run || wrap) && mode_r == MODE_CONT && irq_enable_r && !halt)
         |=> irq;
   endproperty
   a_cont_irq: assert property (p_cont_irq)
      else $error("no interrupt at shadow load");

   property p_cnt_bound;
      @(posedge clk) disable iff (reset)
      state_r == ST_RUN |-> cnt_r <= sh_cycle_r;
   endproperty
   a_cnt_bound: assert property (p_cnt_bound)
      else $error("period counter past its end");

   property p_shadow;
      @(posedge clk) disable iff (reset)
      start_run |=> sh_cycle_r == $past(cycle_length_r)
         && sh_lead_r == $past(lead_span_r);
   endproperty
   a_shadow: assert property (p_shadow)
      else $error("shadow copies not loaded at start");

   property p_lead_level;
      @(posedge clk) disable iff (reset)
      (start_run && mode_on && lead_span_r != 32'h0) |=>
         waveform_out == $past(lead_level_r);
   endproperty
   a_lead_level: assert property (p_lead_level)
      else $error("period did not open at lead level");
endmodule
`default_nettype wire

// File: pwmwg_pkg.sv
// package for the pulse-width waveform generator
// assumes a 32-bit register port with byte offsets as printed
package pwmwg_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_IDENT = 8'h00;
   localparam logic [7:0] OFS_UNIT = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_GO = 8'h0C;
   localparam logic [7:0] OFS_RPT = 8'h10;
   localparam logic [7:0] OFS_CYCLE = 8'h14;
   localparam logic [7:0] OFS_LEAD = 8'h18;
   // configuration field positions
   localparam int CFG_RUN_BIT = 17;
   localparam int CFG_PIN_BIT = 16;
   localparam int CFG_IRQ_BIT = 6;
   localparam int CFG_IDLE_BIT = 5;
   localparam int CFG_LEAD_BIT = 4;
   localparam int CFG_TRIG_LSB = 2;
   localparam int CFG_MODE_LSB = 0;
   localparam int UNIT_FREE_BIT = 0;
   localparam int GO_BIT = 0;
   // identity fields; values are arbitrary
   localparam logic [1:0] ID_SCHEME = 2'h1;
   localparam logic [11:0] ID_FUNC = 12'hA5C;
   localparam logic [4:0] ID_IMPL = 5'h03;
   localparam logic [2:0] ID_MAJOR = 3'h2;
   localparam logic [1:0] ID_CUSTOM = 2'h0;
   localparam logic [5:0] ID_MINOR = 6'h01;
   // reset values
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] RST_RPT = 8'h00;
   // mode and trigger codes
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ONESHOT = 2'b01,
      MODE_CONT = 2'b10,
      MODE_RSVD = 2'b11
   } pwmwg_mode_t;
   typedef enum logic [1:0] {
      TRIG_NONE = 2'b00,
      TRIG_RISE = 2'b01,
      TRIG_FALL = 2'b10,
      TRIG_RSVD = 2'b11
   } pwmwg_trig_t;
   // generator states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN = 2'b10
   } pwmwg_state_t;
endpackage

// File: pwmwg_load.sv
// external load hanging on the waveform pin
// assumes it shares the generator clock; it only watches the pin
`timescale 1ns/1ps
`default_nettype none
module pwmwg_load (
   // clock
   input wire logic clk,
   // driven pin
   input wire logic waveform_out,
   // tally for the bench
   output int high_cycles
);
   // purely resistive load: no feedback, just time spent high
   initial high_cycles = 0;
   // sampled mid-cycle so the registered pin has settled
   always @(negedge clk) begin
      if (waveform_out === 1'b1) begin
         high_cycles = high_cycles + 1;
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
// self-checking bench for the waveform generator
// assumes the register port answers a read in the following cycle
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pwmwg_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic trigger_in = 1'b0;
   logic emu_suspend = 1'b0;
   logic power_down = 1'b0;
   logic fz;
   logic [31:0] d;
   wire logic [31:0] reg_rdata;
   wire logic waveform_out;
   wire logic irq;
   wire logic dma_sync_request;
   int high_cycles, irqs, cycle_length, span, h0, i;
   int bad_count = 0;
   int compares = 0;
   int seed = 32'hf26d;
   logic [7:0] offs [7] = '{OFS_UNIT, OFS_CFG, OFS_GO, OFS_RPT, OFS_CYCLE,
      OFS_LEAD, 8'h1C};
   logic exp_q[$];
   pwmwg_top i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .trigger_in(trigger_in),
      .emu_suspend(emu_suspend), .power_down(power_down),
      .waveform_out(waveform_out), .irq(irq),
      .dma_sync_request(dma_sync_request));
   pwmwg_load i_load (.clk(clk), .waveform_out(waveform_out),
      .high_cycles(high_cycles));
   // 40 MHz clock
   always #12.5 clk = ~clk;
   // one compare; four-state equality so an unknown matches only an unknown
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // bus cycles: one-cycle strobes, changed just after the edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // one cycle of the pin against the model, tallying interrupts
   task automatic tick(input logic exp);
      @(negedge clk);
      chk(waveform_out, exp);
      chk(dma_sync_request, irq);
      irqs += int'(irq);
   endtask
   // n periods from the cycle after the go write; one-shot ends idle
   task automatic run_check(input int n, input logic lead, input bit one);
      irqs = 0;
      h0 = high_cycles;
      // model: queue of expected pin levels, one per cycle
      for (int p = 0; p < n; p++) begin
         for (int c = 0; c <= cycle_length; c++) begin
            exp_q.push_back(lead ^ (c >= span));
         end
      end
      while (exp_q.size() > 0) tick(exp_q.pop_front());
      if (one) begin
         repeat (3) tick(~lead);
         chk(irqs, 1);
         chk(high_cycles - h0, n * ((span > cycle_length + 1) ? cycle_length + 1 : span));
      end else begin
         chk(irqs, n);
      end
   endtask
   task automatic done(input string name);
      $display("test %s finished, compares %0d", name, compares);
   endtask
   task automatic wrap_up;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog well beyond the expected few hundred cycles
   initial begin
      #(25 * 30000);
      bad_count++;
      wrap_up;
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      rd(OFS_IDENT);
      chk(d, {ID_SCHEME, 2'h0, ID_FUNC, ID_IMPL, ID_MAJOR, ID_CUSTOM,
         ID_MINOR});
      wr(OFS_IDENT, 32'hFFFF_FFFF);
      rd(OFS_IDENT);
      chk(d[31:30], ID_SCHEME);
      foreach (offs[k]) begin
         rd(offs[k]);
         chk(d, RST_WORD);
      end
      wr(OFS_UNIT, 32'hFFFF_FFFF);
      rd(OFS_UNIT);
      chk(d, 32'h0000_0001);
      wr(OFS_RPT, 32'hFFFF_FFFF);
      rd(OFS_RPT);
      chk(d, 32'h0000_00FF);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C);
      chk(d, RST_WORD);
      // reserved mode code behaves as off, idle level high shows on pin
      wr(OFS_CFG, 32'hFFFF_FFFF);
      wr(OFS_GO, 32'h0000_0001);
      rd(OFS_CFG);
      chk(d, 32'h0001_007F);
      chk(waveform_out, 1'b1);
      done("registers");
      // one-shot, random period and lead span
      cycle_length = 8 + ($random(seed) & 7);
      span = $random(seed) & 7;
      wr(OFS_CYCLE, cycle_length);
      wr(OFS_LEAD, span);
      wr(OFS_RPT, 32'h0000_0002);
      wr(OFS_CFG, 32'h0000_0051);
      wr(OFS_UNIT, 32'h0000_0000);
      wr(OFS_GO, 32'h0000_0001);
      run_check(3, 1'b1, 1'b1);
      done("one_shot");
      // continuous with the two extreme lead spans
      for (int k = 0; k < 2; k++) begin
         span = k ? cycle_length + 1 : 0;
         wr(OFS_LEAD, span);
         wr(OFS_CFG, 32'h0000_0042);
         wr(OFS_GO, 32'h0000_0001);
         run_check(2, 1'b0, 1'b0);
         rd(OFS_CFG);
         chk(d[17], 1'b1);
         chk(d[16], k == 0);
         wr(OFS_CFG, 32'h0000_0020);
         // registered pin follows one edge after the write lands
         @(posedge clk);
         @(negedge clk);
         chk(waveform_out, 1'b1);
      end
      done("continuous");
      // suspend: frozen with free clear, running with free set
      span = 4;
      wr(OFS_LEAD, span);
      wr(OFS_CFG, 32'h0000_0042);
      wr(OFS_GO, 32'h0000_0001);
      repeat (3) @(posedge clk);
      emu_suspend <= 1'b1;
      @(negedge clk);
      fz = waveform_out;
      irqs = 0;
      repeat (2 * cycle_length) tick(fz);
      chk(irqs, 0);
      wr(OFS_UNIT, 32'h0000_0001);
      irqs = 0;
      for (i = 0; i < 2 * (cycle_length + 1); i++) begin
         @(negedge clk);
         irqs += int'(irq);
      end
      chk(irqs, 2);
      @(posedge clk);
      emu_suspend <= 1'b0;
      wr(OFS_UNIT, 32'h0000_0000);
      done("suspend");
      // power-down exit leaves registers but stops the generator
      power_down <= 1'b1;
      repeat (3) @(posedge clk);
      power_down <= 1'b0;
      repeat (3) @(posedge clk);
      rd(OFS_CFG);
      chk(d[17], 1'b0);
      rd(OFS_CYCLE);
      chk(d, cycle_length);
      done("power_down");
      // triggered one-shot on both edge codes
      wr(OFS_RPT, 32'h0000_0000);
      for (int t = 1; t < 3; t++) begin
         trigger_in <= (t == 2);
         wr(OFS_CFG, 32'h0000_0051 | (t << 2));
         wr(OFS_GO, 32'h0000_0001);
         repeat (6) tick(1'b0);
         @(posedge clk);
         emu_suspend <= (t == 2);
         trigger_in <= ~trigger_in;
         // second pass: edge comes while suspended, runs on release
         if (t == 2) begin
            repeat (4) tick(1'b0);
            @(posedge clk);
            emu_suspend <= 1'b0;
         end
         for (i = 0; i < 8 && waveform_out !== 1'b1; i++) @(negedge clk);
         chk(waveform_out, 1'b1);
         repeat (cycle_length + 6) @(posedge clk);
      end
      done("trigger");
      wrap_up;
   end
endmodule
`default_nettype wire
